/* File: hdl/zqo_ctl.sv */
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "zqo_defines.svh"
module zqo_ctl
	import zqo_pkg::*;
#(
	parameter int INIT_WIN  = `ZQO_INIT_WIN_NCK,
	parameter int OPER_WIN  = `ZQO_OPER_WIN_NCK,
	parameter int SHORT_WIN = `ZQO_SHORT_WIN_NCK,
	parameter int TRP_NS    = `ZQO_TRP_NS,
	parameter int SELF_REFRESH_EXIT_TO_CAL_TIME_NS   = `ZQO_SELF_REFRESH_EXIT_TO_CAL_TIME_NS
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	zqo_if.ctl               lnk
);
	localparam int TRP_CYC  = (TRP_NS * `ZQO_CLK_MHZ + 999) / 1000;
	localparam int SELF_REFRESH_EXIT_TO_CAL_TIME_CYC = (SELF_REFRESH_EXIT_TO_CAL_TIME_NS * `ZQO_CLK_MHZ + 999) / 1000;

	zqo_state_e  st_ff;
	zqo_state_e  nxt_st;
	zqo_cmd_e    req_cmd_ff;
	zqo_cmd_e    nxt_cmd;
	logic        req_ff;
	logic        nxt_req;
	logic [2:0]  req_sel_ff;
	logic [13:0] req_data_ff;
	logic [15:0] wait_ff;
	logic [15:0] nxt_wait;
	logic [15:0] xsf_ff;
	logic [3:0]  ccd_cnt_ff;
	logic        pre_ok_ff;
	logic        first_done_ff;
	logic        odt_sw_ff;
	logic        cke_sw_ff;
	logic [4:0]  cwl_ff;
	logic [3:0]  ccd_ff;
	logic        pre2_ff;
	logic        crc_ff;
	logic        err_ff;

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire acc   = psel_i && penable_i && !pready_o;
	wire done  = psel_i && penable_i && pready_o;
	wire wr_ok = done && pwrite_i && !pslverr_o;
	wire a_cmd  = paddr_i == `ZQO_REG_CMD;
	wire a_pin  = paddr_i == `ZQO_REG_PIN;
	wire a_wcfg = paddr_i == `ZQO_REG_WCFG;
	wire a_stat = paddr_i == `ZQO_REG_STAT;
	wire mapped = a_cmd || a_pin || a_wcfg || a_stat;
	wire busy   = req_ff || (st_ff != ZQO_ST_IDLE);
	wire cmd_take = wr_ok && a_cmd && !busy;
	wire [4:0] w_cwl  = pwdata_i[`ZQO_WCFG_CWL_LSB +: 5];
	wire       w_pre2 = pwdata_i[`ZQO_WCFG_PRE2_BIT];
	wire wcfg_bad = w_pre2 && (w_cwl <= `ZQO_CWL_FORBID);
	wire wcfg_take = wr_ok && a_wcfg && !wcfg_bad;
	wire refuse = (wr_ok && a_cmd && busy) || (wr_ok && a_wcfg && wcfg_bad);
	wire [3:0] ccd_eff = (pre2_ff && crc_ff && (ccd_ff == `ZQO_CCD_FORBID)) ?
		`ZQO_CCD_SAFE : ccd_ff;
	wire [31:0] stat_word = {28'h0, err_ff, lnk.cal_busy,
		1'b0, busy};
	wire [31:0] rd_word = a_cmd ? {2'h0, req_data_ff, 9'h0, req_sel_ff,
		req_cmd_ff} :
		a_pin ? {30'h0, cke_sw_ff, odt_sw_ff} :
		a_wcfg ? {14'h0, crc_ff, pre2_ff, 4'h0, ccd_ff, 3'h0, cwl_ff} :
		stat_word;
	wire [15:0] cal_win = (req_cmd_ff == ZQO_CMD_SHORT_CALIBRATION_CMD) ? 16'(SHORT_WIN) :
		first_done_ff ? 16'(OPER_WIN) : 16'(INIT_WIN);

	////////////////////////////////////////////////////////////////////////
	// issue sequencer
	always_comb begin
		nxt_st   = st_ff;
		nxt_cmd  = ZQO_CMD_NOP;
		nxt_req  = req_ff;
		nxt_wait = wait_ff;
		unique case (st_ff)
			ZQO_ST_IDLE: begin
				if (req_ff && zqo_is_cal(req_cmd_ff)) begin
					if (!pre_ok_ff) begin
						nxt_cmd  = ZQO_CMD_PREA;
						nxt_st   = ZQO_ST_RP;
						nxt_wait = 16'(TRP_CYC);
					end else if (xsf_ff == 16'h0000) begin
						nxt_cmd  = req_cmd_ff;
						nxt_req  = 1'b0;
						nxt_st   = ZQO_ST_QUIET;
						nxt_wait = cal_win;
					end
				end else if (req_ff) begin
					if ((req_cmd_ff != ZQO_CMD_WR) || (ccd_cnt_ff == 4'h0)) begin
						nxt_cmd = req_cmd_ff;
						nxt_req = 1'b0;
					end
				end else if (cmd_take) begin
					nxt_req = 1'b1;
				end
			end
			ZQO_ST_RP: begin
				nxt_wait = wait_ff - 16'h0001;
				if (wait_ff == 16'h0001) begin
					nxt_st = ZQO_ST_IDLE;
				end
			end
			ZQO_ST_QUIET: begin
				nxt_wait = wait_ff - 16'h0001;
				if (wait_ff == 16'h0001) begin
					nxt_st = ZQO_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff         <= ZQO_ST_IDLE;
			req_ff        <= 1'b0;
			wait_ff       <= 16'h0000;
			pre_ok_ff     <= 1'b0;
			first_done_ff <= 1'b0;
			xsf_ff        <= 16'h0000;
			ccd_cnt_ff    <= 4'h0;
		end else begin
			st_ff   <= nxt_st;
			req_ff  <= nxt_req;
			wait_ff <= nxt_wait;
			if (nxt_cmd == ZQO_CMD_PREA) begin
				pre_ok_ff <= 1'b1;
			end else if ((nxt_cmd == ZQO_CMD_RD) || (nxt_cmd == ZQO_CMD_WR)) begin
				pre_ok_ff <= 1'b0;
			end
			if (nxt_cmd == ZQO_CMD_LONG_CALIBRATION_CMD) begin
				first_done_ff <= 1'b1;
			end
			if (nxt_cmd == ZQO_CMD_SRX) begin
				xsf_ff <= 16'(SELF_REFRESH_EXIT_TO_CAL_TIME_CYC);
			end else if (xsf_ff != 16'h0000) begin
				xsf_ff <= xsf_ff - 16'h0001;
			end
			if (nxt_cmd == ZQO_CMD_WR) begin
				ccd_cnt_ff <= ccd_eff - 4'h1;
			end else if (ccd_cnt_ff != 4'h0) begin
				ccd_cnt_ff <= ccd_cnt_ff - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers and apb answer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			req_cmd_ff  <= ZQO_CMD_NOP;
			req_sel_ff  <= 3'h0;
			req_data_ff <= 14'h0000;
			odt_sw_ff   <= 1'b0;
			cke_sw_ff   <= 1'b1;
			cwl_ff      <= `ZQO_CWL_RST;
			ccd_ff      <= `ZQO_CCD_RST;
			pre2_ff     <= 1'b0;
			crc_ff      <= 1'b0;
			err_ff      <= 1'b0;
			prdata_o    <= 32'h0000_0000;
			pready_o    <= 1'b0;
			pslverr_o   <= 1'b0;
		end else begin
			pready_o  <= acc;
			pslverr_o <= acc && !mapped;
			if (acc && !pwrite_i) begin
				prdata_o <= mapped ? rd_word : 32'h0000_0000;
			end
			if (cmd_take) begin
				req_cmd_ff  <= zqo_cmd_e'(pwdata_i[3:0]);
				req_sel_ff  <= pwdata_i[`ZQO_CMD_SEL_LSB +: 3];
				req_data_ff <= pwdata_i[`ZQO_CMD_DATA_LSB +: 14];
			end
			if (wr_ok && a_pin) begin
				odt_sw_ff <= pwdata_i[0];
				cke_sw_ff <= pwdata_i[1];
			end
			if (wcfg_take) begin
				cwl_ff  <= w_cwl;
				ccd_ff  <= pwdata_i[`ZQO_WCFG_CCD_LSB +: 4];
				pre2_ff <= w_pre2;
				crc_ff  <= pwdata_i[`ZQO_WCFG_CRC_BIT];
			end
			// sticky error, set wins over clear
			if (refuse) begin
				err_ff <= 1'b1;
			end else if (wr_ok && a_stat && pwdata_i[`ZQO_STAT_ERR_BIT]) begin
				err_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link drive
	wire quiet_n = (nxt_st != ZQO_ST_QUIET) && (st_ff != ZQO_ST_QUIET);
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lnk.cmd     <= ZQO_CMD_NOP;
			lnk.mr_sel  <= 3'h0;
			lnk.mr_data <= 14'h0000;
			lnk.odt     <= 1'b0;
			lnk.cke     <= 1'b1;
		end else begin
			lnk.cmd     <= nxt_cmd;
			lnk.mr_sel  <= req_sel_ff;
			lnk.mr_data <= req_data_ff;
			lnk.odt     <= odt_sw_ff && quiet_n;
			// clock enable held high during calibration
			lnk.cke     <= cke_sw_ff || !quiet_n;
		end
	end
endmodule

/* File: hdl/zqo_defines.svh */
`ifndef ZQO_DEFINES_SVH
`define ZQO_DEFINES_SVH
// clock
`define ZQO_CLK_MHZ        40
// calibration windows in memory clocks
`define ZQO_INIT_WIN_NCK   1024
`define ZQO_OPER_WIN_NCK   512
`define ZQO_SHORT_WIN_NCK  64
// termination periods and latency in memory clocks
`define ZQO_WR_PERIOD_NCK  6
`define ZQO_RD_PERIOD_NCK  6
`define ZQO_NOM_LAT_NCK    7
// controller times in ns
`define ZQO_TRP_NS         15
`define ZQO_SELF_REFRESH_EXIT_TO_CAL_TIME_NS        300
// mode register fields
`define ZQO_MR1_NOM_LSB    8
`define ZQO_MR1_TERMINATION_STROBE_PAIR_BIT   11
`define ZQO_MR2_WR_LSB     9
`define ZQO_MR5_PARK_LSB   6
// apb register offsets
`define ZQO_REG_CMD        8'h00
`define ZQO_REG_PIN        8'h04
`define ZQO_REG_WCFG       8'h08
`define ZQO_REG_STAT       8'h0c
// cmd register fields
`define ZQO_CMD_SEL_LSB    4
`define ZQO_CMD_DATA_LSB   16
// wcfg register fields
`define ZQO_WCFG_CWL_LSB   0
`define ZQO_WCFG_CCD_LSB   8
`define ZQO_WCFG_PRE2_BIT  16
`define ZQO_WCFG_CRC_BIT   17
// write configuration values
`define ZQO_CWL_RST        5'h09
`define ZQO_CWL_FORBID     5'h09
`define ZQO_CCD_RST        4'h4
`define ZQO_CCD_FORBID     4'h6
`define ZQO_CCD_SAFE       4'h7
// status bits
`define ZQO_STAT_PEND_BIT  0
`define ZQO_STAT_CAL_BIT   1
`define ZQO_STAT_SR_BIT    2
`define ZQO_STAT_ERR_BIT   3
`endif

/* File: hdl/zqo_pkg.sv */
package zqo_pkg;
	typedef enum logic [3:0] {
		ZQO_CMD_NOP,
		ZQO_CMD_MRS,
		ZQO_CMD_PREA,
		ZQO_CMD_LONG_CALIBRATION_CMD,
		ZQO_CMD_SHORT_CALIBRATION_CMD,
		ZQO_CMD_SRE,
		ZQO_CMD_SRX,
		ZQO_CMD_RD,
		ZQO_CMD_WR
	} zqo_cmd_e;
	typedef enum logic [1:0] {
		ZQO_TERM_OFF,
		ZQO_TERM_WR,
		ZQO_TERM_NOM,
		ZQO_TERM_PARK
	} zqo_term_e;
	typedef enum logic [1:0] {
		ZQO_ST_IDLE,
		ZQO_ST_RP,
		ZQO_ST_QUIET
	} zqo_state_e;
	function automatic logic zqo_is_cal(input zqo_cmd_e c);
		return (c == ZQO_CMD_LONG_CALIBRATION_CMD) || (c == ZQO_CMD_SHORT_CALIBRATION_CMD);
	endfunction
endpackage

/* File: hdl/zqo_if.sv */
`timescale 1ns/100ps
interface zqo_if;
	import zqo_pkg::*;
	zqo_cmd_e    cmd;
	logic [2:0]  mr_sel;
	logic [13:0] mr_data;
	logic        odt;
	logic        cke;
	logic        cal_busy;
	modport dev (input cmd, input mr_sel, input mr_data, input odt,
		input cke, output cal_busy);
	modport ctl (output cmd, output mr_sel, output mr_data, output odt,
		output cke, input cal_busy);
endinterface

/* File: hdl/zqo_dev.sv */
`timescale 1ns/100ps
`include "zqo_defines.svh"
////////////////////////////////////////////////////////////////////////////
// Function
// - first long cal after reset: init window
// - short cal finishes within short window
// - controller keeps channel quiet during windows
// - controller precharges, waits precharge time first
// - no self calibration after self refresh
// - controller waits exit time before calibration
// - shared resistor windows never overlap
// - clock enable high, bus idle during cal
// - termination off during calibration
// - self refresh: termination off, pin ignored
// - nominal disabled: termination pin ignored
// - termination enabled by any nonzero field
// - priority: off, write, nominal, park
// - write termination during write period
// - nominal applied only with pin high
// - park when pin low or nominal off
// - read forces high impedance for period
// - nominal disabled powers down pin receiver
// - field codes map to ohm values
// - strobe pair terminated only if enabled
// - two-clock preamble forbids write latency 9
// - two-clock preamble with crc forbids spacing 6
// - nominal follows pin after fixed latency
module zqo_dev
	import zqo_pkg::*;
#(
	parameter int INIT_WIN  = `ZQO_INIT_WIN_NCK,
	parameter int OPER_WIN  = `ZQO_OPER_WIN_NCK,
	parameter int SHORT_WIN = `ZQO_SHORT_WIN_NCK,
	parameter int WR_PERIOD = `ZQO_WR_PERIOD_NCK,
	parameter int RD_PERIOD = `ZQO_RD_PERIOD_NCK,
	parameter int NOM_LAT   = `ZQO_NOM_LAT_NCK
) (
	input  wire logic clk_i,
	input  wire logic srst_i,
	zqo_if.dev        lnk,
	output zqo_term_e term_state_o,
	output logic [2:0] term_code_o,
	output logic [7:0] term_ohm_o,
	output logic      termination_strobe_pair_term_o,
	output logic      odt_rx_en_o,
	output logic      self_refresh_o,
	output logic      cal_busy_o
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ohm_of(input logic [2:0] code);
		logic [7:0] r;
		r = 8'h00;
		unique case (code)
			3'h0: r = 8'h00;
			3'h1: r = 8'hf0;
			3'h2: r = 8'h78;
			3'h3: r = 8'h50;
			3'h4: r = 8'h3c;
			3'h5: r = 8'h30;
			3'h6: r = 8'h28;
			3'h7: r = 8'h22;
		endcase
		return r;
	endfunction

	logic [15:0]        cal_cnt_ff;
	logic [15:0]        nxt_cal_cnt;
	logic               first_done_ff;
	logic               sr_ff;
	logic [2:0]         nom_ff;
	logic [2:0]         wr_ff;
	logic [2:0]         park_ff;
	logic               termination_strobe_pair_ff;
	logic [NOM_LAT-1:0] odt_pipe_ff;
	logic [7:0]         wr_cnt_ff;
	logic [7:0]         rd_cnt_ff;
	zqo_term_e          nxt_state;
	logic [2:0]         nxt_code;

	////////////////////////////////////////////////////////////////////////
	// command decode
	wire is_mrs  = lnk.cmd == ZQO_CMD_MRS;
	wire is_long_calibration_cmd = lnk.cmd == ZQO_CMD_LONG_CALIBRATION_CMD;
	wire is_cal  = zqo_is_cal(lnk.cmd);
	wire is_rd   = lnk.cmd == ZQO_CMD_RD;
	wire is_wr   = lnk.cmd == ZQO_CMD_WR;
	wire cal_act = cal_cnt_ff != 16'h0000;
	wire wr_act  = wr_cnt_ff != 8'h00;
	wire rd_act  = rd_cnt_ff != 8'h00;
	wire any_en  = (nom_ff != 3'h0) || (wr_ff != 3'h0) || (park_ff != 3'h0);
	wire rx_en   = (nom_ff != 3'h0) && !sr_ff;
	wire odt_in  = lnk.odt && rx_en;
	wire odt_lat = odt_pipe_ff[NOM_LAT-1];
	wire force_off = cal_act || sr_ff || rd_act || !any_en;

	////////////////////////////////////////////////////////////////////////
	// calibration window
	always_comb begin
		nxt_cal_cnt = cal_cnt_ff;
		if (cal_act) begin
			nxt_cal_cnt = cal_cnt_ff - 16'h0001;
		end else if (is_long_calibration_cmd) begin
			nxt_cal_cnt = first_done_ff ? 16'(OPER_WIN) : 16'(INIT_WIN);
		end else if (is_cal) begin
			nxt_cal_cnt = 16'(SHORT_WIN);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cal_cnt_ff    <= 16'h0000;
			first_done_ff <= 1'b0;
		end else begin
			cal_cnt_ff <= nxt_cal_cnt;
			if (is_long_calibration_cmd && !cal_act) begin
				first_done_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// self refresh, no calibration on exit
	// exit only clears flag
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sr_ff <= 1'b0;
		end else if (lnk.cmd == ZQO_CMD_SRE) begin
			sr_ff <= 1'b1;
		end else if (lnk.cmd == ZQO_CMD_SRX) begin
			sr_ff <= 1'b0;
		end
	end

	// mode register fields
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nom_ff  <= 3'h0;
			wr_ff   <= 3'h0;
			park_ff <= 3'h0;
			termination_strobe_pair_ff <= 1'b0;
		end else if (is_mrs) begin
			unique case (lnk.mr_sel)
				3'h1: begin
					nom_ff  <= lnk.mr_data[`ZQO_MR1_NOM_LSB +: 3];
					termination_strobe_pair_ff <= lnk.mr_data[`ZQO_MR1_TERMINATION_STROBE_PAIR_BIT];
				end
				3'h2: wr_ff   <= lnk.mr_data[`ZQO_MR2_WR_LSB +: 3];
				3'h5: park_ff <= lnk.mr_data[`ZQO_MR5_PARK_LSB +: 3];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin latency and read/write periods
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			odt_pipe_ff <= '0;
			wr_cnt_ff   <= 8'h00;
			rd_cnt_ff   <= 8'h00;
		end else begin
			odt_pipe_ff <= {odt_pipe_ff[NOM_LAT-2:0], odt_in};
			if (is_wr && (wr_ff != 3'h0)) begin
				wr_cnt_ff <= 8'(WR_PERIOD);
			end else if (wr_act) begin
				wr_cnt_ff <= wr_cnt_ff - 8'h01;
			end
			if (is_rd) begin
				rd_cnt_ff <= 8'(RD_PERIOD);
			end else if (rd_act) begin
				rd_cnt_ff <= rd_cnt_ff - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// termination resolve
	always_comb begin
		nxt_state = ZQO_TERM_OFF;
		nxt_code  = 3'h0;
		if (force_off) begin
			nxt_state = ZQO_TERM_OFF;
		end else if (wr_act && (wr_ff != 3'h0)) begin
			nxt_state = ZQO_TERM_WR;
			nxt_code  = wr_ff;
		end else if (odt_lat && (nom_ff != 3'h0)) begin
			nxt_state = ZQO_TERM_NOM;
			nxt_code  = nom_ff;
		end else if (park_ff != 3'h0) begin
			nxt_state = ZQO_TERM_PARK;
			nxt_code  = park_ff;
		end
	end

	// write field limited to three values
	wire [7:0] nxt_ohm = ((nxt_state == ZQO_TERM_WR) && (nxt_code > 3'h3)) ?
		8'h00 : ohm_of(nxt_code);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			term_state_o   <= ZQO_TERM_OFF;
			term_code_o    <= 3'h0;
			term_ohm_o     <= 8'h00;
			termination_strobe_pair_term_o    <= 1'b0;
			odt_rx_en_o    <= 1'b0;
			self_refresh_o <= 1'b0;
			cal_busy_o     <= 1'b0;
			lnk.cal_busy   <= 1'b0;
		end else begin
			term_state_o   <= nxt_state;
			term_code_o    <= nxt_code;
			term_ohm_o     <= nxt_ohm;
			termination_strobe_pair_term_o    <= termination_strobe_pair_ff && (nxt_state != ZQO_TERM_OFF);
			odt_rx_en_o    <= rx_en;
			self_refresh_o <= sr_ff;
			cal_busy_o     <= nxt_cal_cnt != 16'h0000;
			lnk.cal_busy   <= nxt_cal_cnt != 16'h0000;
		end
	end
endmodule

/* File: dv/zqo_cal_asserts.sv */
`timescale 1ns/100ps
module zqo_cal_asserts
	import zqo_pkg::*;
#(
	parameter int INIT_WIN  = 1024,
	parameter int OPER_WIN  = 512,
	parameter int SHORT_WIN = 64
) (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire zqo_cmd_e    cmd,
	input wire logic [2:0]  mr_sel,
	input wire logic [13:0] mr_data,
	input wire logic        odt,
	input wire logic        cke,
	input wire logic        cal_busy
);
	logic        zq_cmd;
	logic        prev_zq_ff;
	logic        prech_ff;
	logic        seen_ff;
	logic [7:0]  srx_ff;
	logic [15:0] blen_ff;
	int          exp_ff;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	assign zq_cmd = (cmd == ZQO_CMD_LONG_CALIBRATION_CMD) || (cmd == ZQO_CMD_SHORT_CALIBRATION_CMD);
	////////////////////////////////////////////////////////////////////////
	// helper state: precharge, exit distance, window length
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prev_zq_ff <= 1'h0;
			prech_ff   <= 1'h0;
			seen_ff    <= 1'h0;
			srx_ff     <= 8'hff;
			blen_ff    <= 16'h0;
			exp_ff     <= 0;
		end else begin
			prev_zq_ff <= zq_cmd;
			if (cmd == ZQO_CMD_PREA)
				prech_ff <= 1'h1;
			else if (cmd == ZQO_CMD_RD || cmd == ZQO_CMD_WR)
				prech_ff <= 1'h0;
			if (cmd == ZQO_CMD_SRX)
				srx_ff <= 8'h0;
			else if (srx_ff != 8'hff)
				srx_ff <= srx_ff + 8'h1;
			blen_ff <= cal_busy ? blen_ff + 16'h1 : 16'h0;
			if (zq_cmd && !cal_busy) begin
				exp_ff <= (cmd == ZQO_CMD_SHORT_CALIBRATION_CMD) ? SHORT_WIN :
					(seen_ff ? OPER_WIN : INIT_WIN);
				seen_ff <= seen_ff | (cmd == ZQO_CMD_LONG_CALIBRATION_CMD);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_cal_cmd;
		zq_cmd && !cal_busy;
	endsequence
	a_busy_follows: assert property (s_cal_cmd |=> cal_busy[*3])
		else $error("cal busy not raised after cal command");
	a_window_len: assert property ($fell(cal_busy) |->
		(blen_ff >= exp_ff && blen_ff <= exp_ff + 2))
		else $error("cal window length wrong");
	a_busy_cause: assert property ($rose(cal_busy) |-> prev_zq_ff)
		else $error("cal busy rose without command");
	a_quiet_chan: assert property (cal_busy |-> cmd == ZQO_CMD_NOP)
		else $error("command sent during cal window");
	a_odt_off_cal: assert property ((zq_cmd || cal_busy) |-> !odt)
		else $error("odt high during calibration");
	a_cke_high_cal: assert property ((zq_cmd || cal_busy) |-> cke)
		else $error("cke low during calibration");
	a_prech_first: assert property (zq_cmd |-> prech_ff)
		else $error("cal command without precharge");
	a_srx_gap: assert property (zq_cmd |-> srx_ff >= 8'd11)
		else $error("cal command too soon after exit");
endmodule

/* File: dv/test_zq_calibration_and_odt_control.sv */
`timescale 1ns/100ps
module test_zq_calibration_and_odt_control
	import zqo_pkg::*;
;
	logic        clk_i = 1'h0;
	logic        srst_i = 1'h1;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [7:0]  paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rd_v, lfsr_v = 32'h84a8;
	logic        pready_o, pslverr_o, termination_strobe_pair_term_o, odt_rx_en_o, serr;
	logic        self_refresh_o, cal_busy_o;
	logic [2:0]  term_code_o;
	logic [7:0]  term_ohm_o;
	zqo_term_e   term_state_o, wr_snap, rd_snap;
	zqo_cmd_e    c1, c2;
	int          error_cnt = 0, n_tests = 0, run = 0, blast = 0;
	int          cyc = 0, last_wr = 0, wr_gap = 0;
	logic [7:0]  ohm_tab [8] = '{8'h00, 8'hf0, 8'h78, 8'h50, 8'h3c, 8'h30,
		8'h28, 8'h22};
	zqo_if lnk ();
	zqo_dev zqo_dev_inst (
		.clk_i(clk_i), .srst_i(srst_i), .lnk(lnk),
		.term_state_o(term_state_o), .term_code_o(term_code_o),
		.term_ohm_o(term_ohm_o), .termination_strobe_pair_term_o(termination_strobe_pair_term_o),
		.odt_rx_en_o(odt_rx_en_o), .self_refresh_o(self_refresh_o),
		.cal_busy_o(cal_busy_o));
	zqo_ctl zqo_ctl_inst (
		.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .lnk(lnk));
	zqo_cal_asserts zqo_cal_asserts_inst (
		.clk_i(clk_i), .srst_i(srst_i),
		.cmd(lnk.cmd), .mr_sel(lnk.mr_sel), .mr_data(lnk.mr_data),
		.odt(lnk.odt), .cke(lnk.cke), .cal_busy(lnk.cal_busy));
	always #12.5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	// link monitor
	always @(posedge clk_i) begin
		c1 <= lnk.cmd;
		c2 <= c1;
		cyc <= cyc + 1;
		if (c2 == ZQO_CMD_WR)
			wr_snap <= term_state_o;
		if (c2 == ZQO_CMD_RD)
			rd_snap <= term_state_o;
		run <= cal_busy_o ? run + 1 : 0;
		if (!cal_busy_o && run != 0)
			blast <= run;
		if (lnk.cmd == ZQO_CMD_WR) begin
			wr_gap <= cyc - last_wr;
			last_wr <= cyc;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'h1);
		rd_v = prdata_o;
		serr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic send(input zqo_cmd_e c, input logic [2:0] s,
		input logic [13:0] d);
		int k;
		apb(1'h1, 8'h00, {2'h0, d, 9'h0, s, c});
		for (k = 0; k < 600; k++) begin
			apb(1'h0, 8'h0c, 32'h0);
			if ((rd_v & 32'h5) === 32'h0)
				break;
		end
		if (k == 600)
			error_cnt++;
	endtask
	task automatic cal(input zqo_cmd_e c, input int w);
		send(c, 3'h0, 14'h0);
		repeat (3) @(posedge clk_i);
		check("cal window", 32'(blast >= w && blast <= w + 2), 32'h1);
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic zqo_term_e exp_st(input logic [2:0] n, p,
		input logic o);
		if (n != 3'h0 && o)
			return ZQO_TERM_NOM;
		if (p != 3'h0)
			return ZQO_TERM_PARK;
		return ZQO_TERM_OFF;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [2:0] n, p, w, cd;
		logic       t, o;
		zqo_term_e  st;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'h0;
		@(posedge clk_i);
		apb(1'h0, 8'h10, 32'h0);
		check("unmapped err", 32'(serr), 32'h1);
		cal(ZQO_CMD_LONG_CALIBRATION_CMD, 1024);
		cal(ZQO_CMD_LONG_CALIBRATION_CMD, 512);
		cal(ZQO_CMD_SHORT_CALIBRATION_CMD, 64);
		apb(1'h1, 8'h00, 32'(ZQO_CMD_LONG_CALIBRATION_CMD));
		send(ZQO_CMD_SHORT_CALIBRATION_CMD, 3'h0, 14'h0);
		repeat (3) @(posedge clk_i);
		check("refused cal", 32'(blast >= 512), 32'h1);
		apb(1'h0, 8'h0c, 32'h0);
		check("err set", rd_v, 32'h8);
		apb(1'h1, 8'h0c, 32'h8);
		apb(1'h0, 8'h0c, 32'h0);
		check("err clear", rd_v, 32'h0);
		apb(1'h1, 8'h08, 32'h10409);
		apb(1'h0, 8'h08, 32'h0);
		check("pre2 cwl", rd_v, 32'h409);
		apb(1'h0, 8'h0c, 32'h0);
		check("cwl err", rd_v, 32'h8);
		apb(1'h1, 8'h08, 32'h3060a);
		apb(1'h1, 8'h00, 32'(ZQO_CMD_WR));
		send(ZQO_CMD_WR, 3'h0, 14'h0);
		check("wr spacing", 32'(wr_gap), 32'h7);
		for (int i = 0; i < 12; i++) begin
			lfsr_v = nxt(lfsr_v);
			{t, o, w, p, n} = lfsr_v[10:0];
			if (i < 2)
				{o, p, n} = i ? 7'h7f : 7'h40;
			w[2] = 1'h0;
			send(ZQO_CMD_MRS, 3'h1, {2'h0, t, n, 8'h0});
			send(ZQO_CMD_MRS, 3'h2, {2'h0, w, 9'h0});
			send(ZQO_CMD_MRS, 3'h5, {5'h0, p, 6'h0});
			apb(1'h1, 8'h04, {30'h0, 1'h1, o});
			repeat (12) @(posedge clk_i);
			st = exp_st(n, p, o);
			cd = (st == ZQO_TERM_NOM) ? n : (st == ZQO_TERM_PARK) ? p : 3'h0;
			check("term state", 32'(term_state_o), 32'(st));
			check("term code", 32'(term_code_o), 32'(cd));
			check("term ohm", 32'(term_ohm_o), 32'(ohm_tab[cd]));
			check("termination_strobe_pair", 32'(termination_strobe_pair_term_o), 32'(t && st != ZQO_TERM_OFF));
			check("odt rx", 32'(odt_rx_en_o), 32'(n != 3'h0));
			send(ZQO_CMD_WR, 3'h0, 14'h0);
			st = (w != 3'h0) ? ZQO_TERM_WR : st;
			check("wr term", 32'(wr_snap), 32'(st));
			send(ZQO_CMD_RD, 3'h0, 14'h0);
			check("rd term", 32'(rd_snap), 32'(ZQO_TERM_OFF));
		end
		apb(1'h1, 8'h04, 32'h3);
		send(ZQO_CMD_SRE, 3'h0, 14'h0);
		repeat (3) @(posedge clk_i);
		check("sr flag", 32'(self_refresh_o), 32'h1);
		check("sr term", 32'(term_state_o), 32'(ZQO_TERM_OFF));
		check("sr rx", 32'(odt_rx_en_o), 32'h0);
		send(ZQO_CMD_SRX, 3'h0, 14'h0);
		check("no self cal", 32'(cal_busy_o), 32'h0);
		cal(ZQO_CMD_SHORT_CALIBRATION_CMD, 64);
		print_verdict();
	end
endmodule
